// *** inc/bstp_pkg.sv ***
// Purpose: constants and types for the boundary-scan test port
// Assumes: test port clock is sampled by mclk (200 MHz)
// Notes: instruction register width and codes are plain defaults
package bstp_pkg;
    localparam int IR_WIDTH = 4;
    localparam logic [3:0] IR_RESET_VAL = 4'hF;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [1:0] IR_CAPTURE_VAL = 2'h1;
    localparam logic [1:0] SYNC_RESET_VAL = 2'h0;
    localparam logic TDO_RESET_VAL = 1'b0;
    localparam logic FEATURE_SELECT_TAP = 1'b0;

    typedef enum logic [3:0] {
        BSTP_RESET, BSTP_IDLE,
        BSTP_SEL_DR, BSTP_CAP_DR, BSTP_SHIFT_DR, BSTP_EXIT1_DR, BSTP_PAUSE_DR, BSTP_EXIT2_DR, BSTP_UPD_DR,
        BSTP_SEL_IR, BSTP_CAP_IR, BSTP_SHIFT_IR, BSTP_EXIT1_IR, BSTP_PAUSE_IR, BSTP_EXIT2_IR, BSTP_UPD_IR
    } bstp_state_e;
endpackage

// *** rtl/bstp_sync.sv ***
// Purpose: two-flop synchroniser for a pin into the mclk domain
// Assumes: d is asynchronous to mclk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module bstp_sync
#(
    parameter logic RESET_VAL = 1'b0
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_r;
    logic meta_nxt;
    logic q_r;
    logic q_nxt;

    always_comb
    begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= RESET_VAL;
            q_r <= RESET_VAL;
        end
        else
        begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

// *** rtl/bstp_port.sv ***
// Purpose: boundary-scan test access port with global pin tri-state
// Assumes: test clock edges found by sampling with mclk; pin period well above 4 mclk periods
// Notes: only bypass register implemented; all instructions select it
// Functional notes
// - Tri-state control high floats every output and I/O pin; low is normal.
// - Low test reset resets controller asynchronously, no clock edge needed.
// - Power-up reset pulse from outside leaves the port in bypass.
// - Mode select sampled on rising test clock steps the controller.
// - Instructions and data captured from data input on rising test clock.
// - Data output updated on falling test clock edges.
// - Port active only while framer feature select is 0, tied low here.
`timescale 1ns/1ps
module bstp_port
#(
    parameter int IR_W = bstp_pkg::IR_WIDTH,
    parameter int PIN_COUNT = 8
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic test_port_clock,
    input wire logic test_port_mode_select,
    input wire logic test_port_data_in,
    input wire logic test_port_reset_n,
    input wire logic tristate_all,
    input wire logic [PIN_COUNT-1:0] func_out,
    input wire logic [PIN_COUNT-1:0] func_oe,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe,
    output logic test_port_data_out,
    output logic test_port_data_out_oe
);
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tri_s;
    logic tck_d_r;
    logic tck_d_nxt;
    logic rise;
    logic fall;
    logic tap_rst;
    logic framer_feature_select;
    bstp_pkg::bstp_state_e state_r;
    bstp_pkg::bstp_state_e state_nxt;
    logic [IR_W-1:0] ir_sh_r;
    logic [IR_W-1:0] ir_sh_nxt;
    logic [IR_W-1:0] ir_r;
    logic [IR_W-1:0] ir_nxt;
    logic byp_r;
    logic byp_nxt;
    logic tdo_r;
    logic tdo_nxt;
    logic tdo_en_r;
    logic tdo_en_nxt;

    // Test reset is not synchronised: it must act with no clock at all
    assign tap_rst = rst | ~test_port_reset_n;
    assign framer_feature_select = bstp_pkg::FEATURE_SELECT_TAP;

    bstp_sync #(.RESET_VAL(1'b0)) u_sync_tck (.mclk(mclk), .rst(rst), .d(test_port_clock), .q(tck_s));
    bstp_sync #(.RESET_VAL(1'b1)) u_sync_tms (.mclk(mclk), .rst(rst), .d(test_port_mode_select), .q(tms_s));
    bstp_sync #(.RESET_VAL(1'b1)) u_sync_tdi (.mclk(mclk), .rst(rst), .d(test_port_data_in), .q(tdi_s));
    bstp_sync #(.RESET_VAL(1'b0)) u_sync_tri (.mclk(mclk), .rst(rst), .d(tristate_all), .q(tri_s));

    always_comb
    begin
        tck_d_nxt = tck_s;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            tck_d_r <= 1'b0;
        else
            tck_d_r <= tck_d_nxt;
    end

    // Mode select and data travel through equal-length synchronisers, so they stay aligned with the clock
    assign rise = tck_s & ~tck_d_r & ~framer_feature_select;
    assign fall = ~tck_s & tck_d_r & ~framer_feature_select;

    always_comb
    begin
        state_nxt = state_r;
        if (rise)
        begin
            case (state_r)
                bstp_pkg::BSTP_RESET: state_nxt = tms_s ? bstp_pkg::BSTP_RESET : bstp_pkg::BSTP_IDLE;
                bstp_pkg::BSTP_IDLE: state_nxt = tms_s ? bstp_pkg::BSTP_SEL_DR : bstp_pkg::BSTP_IDLE;
                bstp_pkg::BSTP_SEL_DR: state_nxt = tms_s ? bstp_pkg::BSTP_SEL_IR : bstp_pkg::BSTP_CAP_DR;
                bstp_pkg::BSTP_CAP_DR: state_nxt = tms_s ? bstp_pkg::BSTP_EXIT1_DR : bstp_pkg::BSTP_SHIFT_DR;
                bstp_pkg::BSTP_SHIFT_DR: state_nxt = tms_s ? bstp_pkg::BSTP_EXIT1_DR : bstp_pkg::BSTP_SHIFT_DR;
                bstp_pkg::BSTP_EXIT1_DR: state_nxt = tms_s ? bstp_pkg::BSTP_UPD_DR : bstp_pkg::BSTP_PAUSE_DR;
                bstp_pkg::BSTP_PAUSE_DR: state_nxt = tms_s ? bstp_pkg::BSTP_EXIT2_DR : bstp_pkg::BSTP_PAUSE_DR;
                bstp_pkg::BSTP_EXIT2_DR: state_nxt = tms_s ? bstp_pkg::BSTP_UPD_DR : bstp_pkg::BSTP_SHIFT_DR;
                bstp_pkg::BSTP_UPD_DR: state_nxt = tms_s ? bstp_pkg::BSTP_SEL_DR : bstp_pkg::BSTP_IDLE;
                bstp_pkg::BSTP_SEL_IR: state_nxt = tms_s ? bstp_pkg::BSTP_RESET : bstp_pkg::BSTP_CAP_IR;
                bstp_pkg::BSTP_CAP_IR: state_nxt = tms_s ? bstp_pkg::BSTP_EXIT1_IR : bstp_pkg::BSTP_SHIFT_IR;
                bstp_pkg::BSTP_SHIFT_IR: state_nxt = tms_s ? bstp_pkg::BSTP_EXIT1_IR : bstp_pkg::BSTP_SHIFT_IR;
                bstp_pkg::BSTP_EXIT1_IR: state_nxt = tms_s ? bstp_pkg::BSTP_UPD_IR : bstp_pkg::BSTP_PAUSE_IR;
                bstp_pkg::BSTP_PAUSE_IR: state_nxt = tms_s ? bstp_pkg::BSTP_EXIT2_IR : bstp_pkg::BSTP_PAUSE_IR;
                bstp_pkg::BSTP_EXIT2_IR: state_nxt = tms_s ? bstp_pkg::BSTP_UPD_IR : bstp_pkg::BSTP_SHIFT_IR;
                bstp_pkg::BSTP_UPD_IR: state_nxt = tms_s ? bstp_pkg::BSTP_SEL_DR : bstp_pkg::BSTP_IDLE;
                default: state_nxt = bstp_pkg::BSTP_RESET;
            endcase
        end
    end

    always_comb
    begin
        ir_sh_nxt = ir_sh_r;
        ir_nxt = ir_r;
        byp_nxt = byp_r;
        if (rise)
        begin
            case (state_r)
                bstp_pkg::BSTP_RESET: ir_nxt = IR_W'(bstp_pkg::IR_BYPASS);
                bstp_pkg::BSTP_CAP_IR: ir_sh_nxt = IR_W'(bstp_pkg::IR_CAPTURE_VAL);
                bstp_pkg::BSTP_SHIFT_IR: ir_sh_nxt = {tdi_s, ir_sh_r[IR_W-1:1]};
                bstp_pkg::BSTP_UPD_IR: ir_nxt = ir_sh_r;
                bstp_pkg::BSTP_CAP_DR: byp_nxt = 1'b0;
                // Every code selects bypass since no other data register exists
                bstp_pkg::BSTP_SHIFT_DR: byp_nxt = tdi_s;
                default: ir_nxt = ir_r;
            endcase
        end
    end

    always_comb
    begin
        tdo_nxt = tdo_r;
        tdo_en_nxt = tdo_en_r;
        if (fall)
        begin
            tdo_en_nxt = (state_r == bstp_pkg::BSTP_SHIFT_DR) || (state_r == bstp_pkg::BSTP_SHIFT_IR);
            if (state_r == bstp_pkg::BSTP_SHIFT_IR)
                tdo_nxt = ir_sh_r[0];
            else if (state_r == bstp_pkg::BSTP_SHIFT_DR)
                tdo_nxt = byp_r;
        end
    end

    always_ff @(posedge mclk or posedge tap_rst)
    begin
        if (tap_rst)
        begin
            state_r <= bstp_pkg::BSTP_RESET;
            ir_sh_r <= IR_W'(bstp_pkg::IR_RESET_VAL);
            ir_r <= IR_W'(bstp_pkg::IR_BYPASS);
            byp_r <= 1'b0;
            tdo_r <= bstp_pkg::TDO_RESET_VAL;
            tdo_en_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            ir_sh_r <= ir_sh_nxt;
            ir_r <= ir_nxt;
            byp_r <= byp_nxt;
            tdo_r <= tdo_nxt;
            tdo_en_r <= tdo_en_nxt;
        end
    end

    // Global float overrides every enable, the test data output included
    assign pin_out = func_out;
    assign pin_oe = tri_s ? '0 : func_oe;
    assign test_port_data_out = tdo_r;
    assign test_port_data_out_oe = tdo_en_r & ~tri_s;
endmodule

// *** test/bstp_port_sva.sv ***
// Purpose: port checks of bstp_port
// Assumes: test clock halves last 6 mclk or more
// Notes: bind at the foot
`timescale 1ns/1ps
module bstp_port_sva
#(
    parameter int PIN_COUNT = 8
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic test_port_clock,
    input wire logic test_port_reset_n,
    input wire logic tristate_all,
    input wire logic [PIN_COUNT-1:0] func_out,
    input wire logic [PIN_COUNT-1:0] func_oe,
    input wire logic [PIN_COUNT-1:0] pin_out,
    input wire logic [PIN_COUNT-1:0] pin_oe,
    input wire logic test_port_data_out,
    input wire logic test_port_data_out_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    AST_PASS: assert property (pin_out == func_out) else $error("pin data");
    AST_FLOAT: assert property (tristate_all [*4] |-> pin_oe == '0 && !test_port_data_out_oe) else $error("float");
    AST_NORM: assert property (!tristate_all [*4] |-> pin_oe == func_oe) else $error("normal");
    AST_TRST: assert property (!test_port_reset_n |-> !test_port_data_out_oe && !test_port_data_out) else $error("trst");
    AST_REL: assert property ($rose(test_port_reset_n) |-> !test_port_data_out_oe [*8]) else $error("bypass");
    AST_TDO: assert property ($changed(test_port_data_out) && $past(test_port_reset_n) |-> !test_port_clock) else $error("tdo");
    AST_OE: assert property ($rose(test_port_data_out_oe) |-> !test_port_clock && !tristate_all) else $error("oe");
    AST_RST: assert property ($fell(rst) |-> !test_port_data_out_oe && pin_oe == func_oe) else $error("rst");
endmodule
bind bstp_port bstp_port_sva #(.PIN_COUNT(PIN_COUNT)) i_sva (.mclk(mclk), .rst(rst),
    .test_port_clock(test_port_clock), .test_port_reset_n(test_port_reset_n), .tristate_all(tristate_all),
    .func_out(func_out), .func_oe(func_oe), .pin_out(pin_out), .pin_oe(pin_oe),
    .test_port_data_out(test_port_data_out), .test_port_data_out_oe(test_port_data_out_oe));

// *** test/bstp_tester.sv ***
// Purpose: boundary-scan tester on the far side
// Assumes: 64 ns test clock, stopped low between steps
// Notes: data set 6 ns before the rise
`timescale 1ns/1ps
module bstp_tester
(
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo_w
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b0;
    end
    // Late read of tdo: the update trails the fall by up to 3 mclk
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #6 tck = 1'b1;
        #32 tck = 1'b0;
        #26 q = tdo_w;
    endtask
endmodule

// *** test/bstp_port_tb.sv ***
// Purpose: self-checking bench of bstp_port
// Assumes: bstp_tester drives the test port pins
// Notes: seed fixed
`timescale 1ns/1ps
module bstp_port_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic tristate_all = 1'b0;
    logic [7:0] func_out = 8'h00;
    logic [7:0] func_oe = 8'h00;
    logic [7:0] pin_out, pin_oe;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe, q;
    // Released line shows the inverse so a stale value never passes
    wire logic tdo_w = tdo_oe ? tdo : ~tdo;
    int num_errors = 0;
    int checks_done = 0;
    bstp_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_w(tdo_w));
    bstp_port i_dut (.mclk(mclk), .rst(rst), .test_port_clock(tck), .test_port_mode_select(tms),
        .test_port_data_in(tdi), .test_port_reset_n(trst_n), .tristate_all(tristate_all), .func_out(func_out),
        .func_oe(func_oe), .pin_out(pin_out), .pin_oe(pin_oe), .test_port_data_out(tdo), .test_port_data_out_oe(tdo_oe));
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want)
        begin
            num_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Walk to shift, move n+1 bits through a w-bit model, exit to idle
    task automatic scan(input logic ir, input int w, input logic [3:0] sr, input int n);
        logic d;
        i_tester.step(1'b0, 1'b1, q);
        i_tester.step(1'b1, 1'b1, q);
        if (ir)
            i_tester.step(1'b1, 1'b1, q);
        i_tester.step(1'b0, 1'b1, q);
        i_tester.step(1'b0, 1'b1, q);
        check(q, sr[0]);
        for (int i = 0; i <= n; i++)
        begin
            d = 1'($urandom);
            i_tester.step(i == n, d, q);
            sr = (sr >> 1) | (4'(d) << (w - 1));
            if (i < n)
                check(q, sr[0]);
            check(tdo_oe, i < n);
        end
        i_tester.step(1'b1, 1'b1, q);
        i_tester.step(1'b0, 1'b1, q);
    endtask
    initial
    begin
        #200000 num_errors++;
        summarize();
    end
    initial
    begin
        void'($urandom(8658));
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #100 i_tester.trst_n = 1'b1;
        #20 check(tdo_oe, 1'b0);
        scan(1'b0, 1, 4'h0, 12);
        scan(1'b1, 4, 4'h1, 9);
        scan(1'b0, 1, 4'h0, 6);
        // Test reset in mid-shift with the test clock stopped
        i_tester.step(1'b1, 1'b1, q);
        i_tester.step(1'b0, 1'b1, q);
        i_tester.step(1'b0, 1'b1, q);
        check(tdo_oe, 1'b1);
        i_tester.trst_n = 1'b0;
        #1 check(tdo_oe, 1'b0);
        #50 i_tester.trst_n = 1'b1;
        scan(1'b0, 1, 4'h0, 4);
        repeat (12)
        begin
            @(posedge mclk);
            func_out <= 8'($urandom);
            func_oe <= 8'($urandom);
            tristate_all <= 1'($urandom);
            repeat (5) @(posedge mclk);
            check(pin_out, func_out);
            check(pin_oe, tristate_all ? 8'h00 : func_oe);
        end
        summarize();
    end
endmodule
